// ==== host_model.sv ====
// host processor model: one-cycle reads and writes at any register address
// assumes the bench clock and read data one cycle after the strobe edge
`timescale 1ns/10ps
module host_model (
    // clock
    input wire logic clock,
    // register bus
    output wdt_pkg::host_req_t host_req,
    input wire logic [7:0] rdata
);
    logic [7:0] got;
    initial host_req = '0;
    // strobe for one edge, then let go with inverted lines
    task automatic access(input logic w, input logic [18:0] a, input logic [7:0] d);
        @(posedge clock);
        host_req <= '{addr: a, wdata: d, rd: !w, wr: w};
        @(posedge clock);
        host_req <= '{addr: ~a, wdata: ~d, rd: 1'h0, wr: 1'h0};
        @(negedge clock);
        got = rdata;
    endtask
endmodule

// ==== processor_watchdog_timer.sv ====
// processor watchdog timer: one control register, countdown on 1/16 s ticks,
// timeout to interrupt/test output or to a timed reset pulse
// assumes the host bus strobes are already synchronous single-cycle accesses
// Behaviour
// RULE_01: the watchdog control is one 8-bit register at address 7FFF7h on the memory bus.
// RULE_02: the two low bits choose the unit: 1/16 s, 1/4 s, 1 s or 4 s.
// RULE_03: bits 6..2 are a 5-bit multiplier and the period is multiplier times unit.
// RULE_04: on expiry the flag sets and interrupt asserts until flag read or register access.
// RULE_05: with steering 0 a timeout pulls the active-low interrupt/test output.
// RULE_06: with steering 1 a timeout drives a 40 to 200 ms low pulse on reset out.
// RULE_07: with steering 1 the register and the test bit clear at the end of the timeout.
// RULE_08: any read or write of the register restarts the countdown from full period; here accesses during a reset pulse are ignored.
// RULE_09: writing 00h disables the watchdog.
// RULE_10: reset clears the register, test enable and alarm enable, disabling the watchdog; srst here clears the register but not the enable inputs.
// RULE_11: a watchdog steered to the interrupt output suppresses the test waveform.
// RULE_12: the output toggles at 512 Hz when test set, alarm enable clear, steer 1 or reg zero.
// RULE_13: the time base and test waveform come from the 32.768 kHz oscillator.
// RULE_14: the count advances on a 1/16 s oscillator tick; the pulse is a fixed tick count.
`timescale 1ns/10ps
module processor_watchdog_timer (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // oscillator pin, 32.768 kHz
    input wire logic osc_in,
    // host register access, one cycle strobes
    input wire wdt_pkg::host_req_t host_req,
    output logic [7:0] rdata,
    // frequency test and alarm enable bits held elsewhere in the clock
    input wire logic freq_test_enable,
    input wire logic alarm_irq_enable,
    output logic freq_test_clear,
    // open-drain outputs: pin low when oe low
    output logic irq_or_test_out,
    output logic irq_or_test_oe_n,
    output logic reset_out,
    output logic reset_oe_n,
    output logic timeout_flag
);
    // oscillator synchroniser and edge detect
    logic osc_s1_q, osc_s2_q, osc_s3_q;
    always_ff @(posedge clock) begin
        osc_s1_q <= osc_in;
        osc_s2_q <= osc_s1_q;
        osc_s3_q <= osc_s2_q;
    end
    wire osc_rise = osc_s2_q & ~osc_s3_q;

    // dividers: 1/16 s tick and 512 Hz test waveform
    logic [10:0] div_q;
    logic test_wave_q;
    wire tick = osc_rise && (div_q == 11'(wdt_pkg::OSC_PER_SIXTEENTH - 1)); // RULE_13 RULE_14
    always_ff @(posedge clock) begin
        if (srst) begin
            div_q <= '0;
            test_wave_q <= 1'b0;
        end else if (osc_rise) begin
            div_q <= div_q + 11'd1;
            if (div_q[4:0] == 5'(wdt_pkg::OSC_PER_TEST_HALF - 1)) begin
                test_wave_q <= ~test_wave_q; // RULE_12
            end
        end
    end

    // register access decode
    wdt_pkg::wdog_reg_t wdog_q;
    wire wdog_hit = host_req.addr == wdt_pkg::WDOG_ADDR; // RULE_01
    wire wdog_wr = host_req.wr && wdog_hit;
    wire wdog_access = (host_req.rd || host_req.wr) && wdog_hit; // RULE_08
    wire flag_rd = host_req.rd && (host_req.addr == wdt_pkg::FLAGS_ADDR);
    wire enabled = wdog_q != wdt_pkg::WDOG_RESET; // RULE_09

    // period in 1/16 s ticks
    function automatic logic [10:0] period_ticks(input wdt_pkg::wdog_reg_t r);
        logic [6:0] unit_ticks;
        unit_ticks = 7'(wdt_pkg::UNIT_00_TICKS);
        case (r.unit) // RULE_02
            2'b00: unit_ticks = 7'(wdt_pkg::UNIT_00_TICKS);
            2'b01: unit_ticks = 7'(wdt_pkg::UNIT_01_TICKS);
            2'b10: unit_ticks = 7'(wdt_pkg::UNIT_10_TICKS);
            default: unit_ticks = 7'(wdt_pkg::UNIT_11_TICKS);
        endcase
        return 11'(r.mult * unit_ticks); // RULE_03
    endfunction

    // countdown state
    typedef enum logic [0:0] {RUN, PULSE} wd_state_t;
    wd_state_t state_q;
    logic [10:0] count_q;
    logic [1:0] pulse_q;
    logic expired_d;
    assign expired_d = state_q == RUN && enabled && !wdog_access && tick
        && count_q <= 11'd1;

    always_ff @(posedge clock) begin
        if (srst) begin
            wdog_q <= wdt_pkg::WDOG_RESET; // RULE_10
            count_q <= '0;
            state_q <= RUN;
            pulse_q <= '0;
        end else begin
            case (state_q)
                RUN: begin
                    if (wdog_wr) begin
                        wdog_q <= host_req.wdata;
                        count_q <= period_ticks(host_req.wdata);
                    end else if (wdog_access) begin
                        count_q <= period_ticks(wdog_q); // RULE_08
                    end else if (expired_d) begin
                        count_q <= period_ticks(wdog_q);
                        if (wdog_q.steer) begin
                            state_q <= PULSE; // RULE_06
                            pulse_q <= 2'(wdt_pkg::RST_PULSE_TICKS);
                        end
                    end else if (tick && enabled) begin
                        count_q <= count_q - 11'd1;
                    end
                end
                PULSE: begin
                    if (tick) begin
                        pulse_q <= pulse_q - 2'd1;
                        if (pulse_q == 2'd1) begin
                            state_q <= RUN;
                            wdog_q <= wdt_pkg::WDOG_RESET; // RULE_07
                            count_q <= '0;
                        end
                    end
                end
                default: state_q <= RUN;
            endcase
        end
    end

    // timeout flag: set wins over clear
    logic flag_q;
    always_ff @(posedge clock) begin
        if (srst) begin
            flag_q <= 1'b0;
        end else if (expired_d) begin
            flag_q <= 1'b1; // RULE_04
        end else if (flag_rd || wdog_access) begin
            flag_q <= 1'b0;
        end
    end
    assign timeout_flag = flag_q;

    // read data and test-bit clear
    logic [7:0] rdata_q;
    logic ft_clr_q;
    always_ff @(posedge clock) begin
        if (srst) begin
            rdata_q <= '0;
            ft_clr_q <= 1'b0;
        end else begin
            rdata_q <= wdog_hit ? wdog_q : 8'h00;
            ft_clr_q <= state_q == PULSE && tick && pulse_q == 2'd1; // RULE_07
        end
    end
    assign rdata = rdata_q;
    assign freq_test_clear = ft_clr_q;

    // interrupt owned by a timeout steered to the pin; set wins over clear
    // a timeout steered to reset sets the flag only, so the pin stays free
    logic irq_q;
    always_ff @(posedge clock) begin
        if (srst) begin
            irq_q <= 1'b0;
        end else if (expired_d && !wdog_q.steer) begin
            irq_q <= 1'b1; // RULE_05
        end else if (flag_rd || wdog_access) begin
            irq_q <= 1'b0; // RULE_04
        end
    end

    // output drive
    wire irq_active = irq_q; // RULE_05 RULE_11
    wire test_on = freq_test_enable && !alarm_irq_enable
        && (wdog_q.steer || !enabled) && test_wave_q; // RULE_12
    assign irq_or_test_out = 1'b0;
    assign irq_or_test_oe_n = !(irq_active || test_on);
    assign reset_out = 1'b0;
    assign reset_oe_n = state_q != PULSE; // RULE_06

    // ticks seen inside a reset pulse, read only by the length checks
    logic [1:0] pulse_seen_q;
    always_ff @(posedge clock) begin
        if (srst || state_q != PULSE) begin
            pulse_seen_q <= '0;
        end else if (tick) begin
            pulse_seen_q <= pulse_seen_q + 2'd1;
        end
    end

    // checks: named steps of a timeout, of a register access restart and of a reset pulse
    sequence wd_expire_s;
        expired_d && !wdog_q.steer;
    endsequence
    sequence restart_s;
        wdog_access && !wdog_wr && state_q == RUN;
    endsequence
    sequence pulse_first_tick_s;
        state_q == PULSE && tick && pulse_seen_q == 2'd0;
    endsequence
    sequence pulse_last_tick_s;
        state_q == PULSE && tick && pulse_seen_q == 2'(wdt_pkg::RST_PULSE_TICKS - 1);
    endsequence

    // flag and interrupt
    flag_sets_a: assert property (@(posedge clock) disable iff (srst) // RULE_04
        wd_expire_s |=> flag_q && !irq_or_test_oe_n)
        else $error("flag or irq missing after timeout");
    flag_rise_a: assert property (@(posedge clock) disable iff (srst) // RULE_04
        $rose(flag_q) |-> $past(expired_d))
        else $error("flag set without a timeout");
    flag_hold_a: assert property (@(posedge clock) disable iff (srst) // RULE_04
        flag_q && !flag_rd && !wdog_access |=> flag_q)
        else $error("flag dropped without a clear");
    flag_read_clears_a: assert property (@(posedge clock) disable iff (srst) // RULE_04
        flag_rd && !expired_d |=> !flag_q)
        else $error("flag read did not clear flag");
    access_clears_a: assert property (@(posedge clock) disable iff (srst) // RULE_04
        wdog_access && !expired_d |=> !flag_q)
        else $error("access did not clear flag");
    steer_irq_a: assert property (@(posedge clock) disable iff (srst) // RULE_05
        flag_q && !wdog_q.steer && enabled |-> !irq_or_test_oe_n)
        else $error("interrupt not held");
    reset_no_irq_a: assert property (@(posedge clock) disable iff (srst) // RULE_05
        $rose(reset_oe_n) && !freq_test_enable |-> irq_or_test_oe_n)
        else $error("reset timeout drove the interrupt");

    // period loading and countdown
    reload_a: assert property (@(posedge clock) disable iff (srst) // RULE_03
        wdog_wr && state_q == RUN |=> count_q == (11'(wdog_q.mult) << (2 * wdog_q.unit)))
        else $error("period not loaded");
    unit_sixteenth_a: assert property (@(posedge clock) disable iff (srst) // RULE_02
        wdog_wr && state_q == RUN && host_req.wdata[1:0] == 2'b00
        |=> count_q == {6'h00, wdog_q.mult})
        else $error("unit code 00 not decoded");
    unit_quarter_a: assert property (@(posedge clock) disable iff (srst) // RULE_02
        wdog_wr && state_q == RUN && host_req.wdata[1:0] == 2'b01
        |=> count_q == {4'h0, wdog_q.mult, 2'h0})
        else $error("unit code 01 not decoded");
    unit_second_a: assert property (@(posedge clock) disable iff (srst) // RULE_02
        wdog_wr && state_q == RUN && host_req.wdata[1:0] == 2'b10
        |=> count_q == {2'h0, wdog_q.mult, 4'h0})
        else $error("unit code 10 not decoded");
    unit_four_a: assert property (@(posedge clock) disable iff (srst) // RULE_02
        wdog_wr && state_q == RUN && host_req.wdata[1:0] == 2'b11
        |=> count_q == {wdog_q.mult, 6'h00})
        else $error("unit code 11 not decoded");
    restart_full_a: assert property (@(posedge clock) disable iff (srst) // RULE_08
        restart_s |=> count_q == (11'(wdog_q.mult) << (2 * wdog_q.unit)))
        else $error("access did not restart the full period");
    count_step_a: assert property (@(posedge clock) disable iff (srst) // RULE_14
        state_q == RUN && enabled && tick && !wdog_access && count_q > 11'd1
        |=> count_q == $past(count_q) - 11'd1)
        else $error("countdown did not step on tick");
    disabled_quiet_a: assert property (@(posedge clock) disable iff (srst) // RULE_09
        !enabled && !flag_q |=> !flag_q)
        else $error("disabled watchdog expired");

    // reset pulse
    pulse_start_a: assert property (@(posedge clock) disable iff (srst) // RULE_06
        expired_d && wdog_q.steer |=> !reset_oe_n)
        else $error("reset pulse not started");
    pulse_early_a: assert property (@(posedge clock) disable iff (srst) // RULE_06
        pulse_first_tick_s |=> !reset_oe_n)
        else $error("reset pulse ended too early");
    pulse_len_a: assert property (@(posedge clock) disable iff (srst) // RULE_06
        pulse_last_tick_s |=> reset_oe_n)
        else $error("reset pulse too long");
    pulse_frozen_a: assert property (@(posedge clock) disable iff (srst) // RULE_06
        state_q == PULSE && !(tick && pulse_q == 2'd1) |=> $stable(wdog_q))
        else $error("register changed during reset pulse");
    pulse_end_a: assert property (@(posedge clock) disable iff (srst) // RULE_07
        $rose(reset_oe_n) |-> wdog_q == 8'h00 && $past(state_q) == PULSE)
        else $error("register not cleared after pulse");
    ft_clear_a: assert property (@(posedge clock) disable iff (srst) // RULE_07
        $rose(reset_oe_n) |-> freq_test_clear)
        else $error("test bit clear missing after pulse");

    // test waveform sharing the interrupt pin
    test_deny_a: assert property (@(posedge clock) disable iff (srst) // RULE_11
        enabled && !wdog_q.steer && !flag_q |-> irq_or_test_oe_n)
        else $error("test waveform not suppressed");
    test_wave_a: assert property (@(posedge clock) disable iff (srst) // RULE_12
        freq_test_enable && !alarm_irq_enable && !flag_q && (wdog_q.steer || !enabled)
        |-> irq_or_test_oe_n == !test_wave_q)
        else $error("test waveform not on the pin");
    alarm_blocks_a: assert property (@(posedge clock) disable iff (srst) // RULE_12
        alarm_irq_enable && !flag_q |-> irq_or_test_oe_n)
        else $error("test waveform with alarm enabled");
    test_release_a: assert property (@(posedge clock) disable iff (srst) // RULE_12
        !freq_test_enable && !flag_q |-> irq_or_test_oe_n)
        else $error("pin pulled with test off and no flag");

    // register access and reset state
    read_data_a: assert property (@(posedge clock) disable iff (srst) // RULE_01
        host_req.rd && wdog_hit |=> rdata == $past(wdog_q))
        else $error("register read data wrong");
    read_other_a: assert property (@(posedge clock) disable iff (srst) // RULE_01
        !wdog_hit |=> rdata == 8'h00)
        else $error("other address returned register");
    reset_clears_a: assert property (@(posedge clock) // RULE_10
        srst |=> wdog_q == 8'h00 && !flag_q && reset_oe_n && irq_or_test_oe_n)
        else $error("reset did not clear the watchdog");

endmodule

// ==== testbench.sv ====
// self-checking bench for the processor watchdog timer
// assumes host_model.sv and an oscillator running at a quarter of the clock
`timescale 1ns/10ps
module testbench;
    localparam int TICK = 8192; // clocks per 1/16 s tick
    logic clock = 1'h0, srst = 1'h1, osc_in = 1'h0, ft_en = 1'h0, al_en = 1'h0;
    logic [1:0] div = 2'h0;
    logic [7:0] rdata, v;
    logic ftc, irq_o, irq_oe_n, rst_o, rst_oe_n, tflag;
    wdt_pkg::host_req_t host_req;
    int err_total = 0, cmp_count = 0, seed = 20330, n, ftc_seen = 0;
    wire irq_pin = irq_oe_n ? 1'h1 : irq_o; // pulled up when released
    wire rst_pin = rst_oe_n ? 1'h1 : rst_o;
    always #5 clock = ~clock;
    // oscillator, and the test bit held outside that the block may clear
    always @(posedge clock) begin
        div <= div + 2'h1;
        osc_in <= div[1];
        if (ftc === 1'h1) begin
            ftc_seen <= ftc_seen + 1;
            ft_en <= 1'h0;
        end
    end
    processor_watchdog_timer processor_watchdog_timer_i (.clock(clock), .srst(srst),
        .osc_in(osc_in), .host_req(host_req), .rdata(rdata), .freq_test_enable(ft_en),
        .alarm_irq_enable(al_en), .freq_test_clear(ftc), .irq_or_test_out(irq_o),
        .irq_or_test_oe_n(irq_oe_n), .reset_out(rst_o), .reset_oe_n(rst_oe_n),
        .timeout_flag(tflag));
    host_model host_model_i (.clock(clock), .host_req(host_req), .rdata(rdata));
    // period in ticks: multiplier times four to the unit code
    function automatic int period_ticks(input logic [7:0] r);
        period_ticks = r[6:2] * (1 << (2 * r[1:0]));
    endfunction
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] d);
        host_model_i.access(w, wdt_pkg::WDOG_ADDR, d);
    endtask
    // count level changes of the interrupt pin over 300 clocks
    task automatic toggles(output int c);
        logic p;
        c = 0;
        p = irq_pin;
        repeat (300) begin
            @(negedge clock);
            if (irq_pin !== p) c++;
            p = irq_pin;
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (97000) @(posedge clock);
        err_total++;
        test_done();
    end
    initial begin
        repeat (20) @(posedge clock);
        srst <= 1'h0;
        acc(1'h0, 8'h00);
        chk("reset reg", 8'h00, host_model_i.got);
        chk("reset flag", 1'h0, tflag);
        v = {1'h0, 7'($random(seed))};
        acc(1'h1, v);
        acc(1'h0, 8'h00);
        chk("readback", v, host_model_i.got);
        host_model_i.access(1'h0, wdt_pkg::ALARM_CTL_ADDR, 8'h00);
        chk("other addr", 8'h00, host_model_i.got);
        acc(1'h1, 8'h00);
        repeat (2 * TICK) @(negedge clock);
        chk("disabled", 1'h0, tflag);
        $display("test register done");
        ft_en <= 1'h1;
        acc(1'h1, 8'h04);
        for (n = 0; n < (period_ticks(8'h04) + 1) * TICK && tflag !== 1'h1; n++)
            @(negedge clock);
        toggles(n);
        chk("flag set", 1'h1, tflag);
        chk("irq low", 1'h0, irq_pin);
        chk("irq held", 0, n);
        acc(1'h0, 8'h00);
        toggles(n);
        chk("flag cleared", 1'h0, tflag);
        chk("test denied", 0, n);
        for (n = 0; n < 2 * TICK && tflag !== 1'h1; n++) @(negedge clock);
        chk("flag again", 1'h1, tflag);
        host_model_i.access(1'h0, wdt_pkg::FLAGS_ADDR, 8'h00);
        chk("flag read clears", 1'h0, tflag);
        chk("irq released", 1'h1, irq_pin);
        $display("test interrupt done");
        acc(1'h1, 8'h08);
        repeat (4) begin
            repeat (6000) @(posedge clock);
            acc(1'h0, 8'h00);
        end
        chk("restarted", 1'h0, tflag);
        $display("test restart done");
        acc(1'h1, 8'h84);
        for (n = 0; n < 2 * TICK && rst_pin !== 1'h0; n++) @(negedge clock);
        for (n = 0; n < 4 * TICK && rst_pin === 1'h0; n++) @(negedge clock);
        chk("pulse min", 1, n >= 5243);
        chk("pulse max", 1, n <= 26214);
        acc(1'h0, 8'h00);
        chk("reg cleared", 8'h00, host_model_i.got);
        chk("test cleared", 1, ftc_seen);
        ft_en <= 1'h1;
        toggles(n);
        chk("test wave", 1, n >= 2);
        al_en <= 1'h1;
        toggles(n);
        chk("alarm blocks", 1, n <= 1);
        $display("test reset pulse done");
        test_done();
    end
endmodule

// ==== wdt_pkg.sv ====
// package for the processor watchdog: register map, field layout, timing constants
// assumes a 100 MHz system clock and a 32.768 kHz oscillator sampled as a pin
package wdt_pkg;
    localparam logic [18:0] WDOG_ADDR = 19'h7fff7;
    localparam logic [18:0] FLAGS_ADDR = 19'h7fff0;
    localparam logic [18:0] ALARM_CTL_ADDR = 19'h7fff6;
    localparam logic [7:0] WDOG_RESET = 8'h00;
    localparam int STEER_BIT = 7;
    localparam int MULT_LSB = 2;
    localparam int FLAG_BIT = 7;
    localparam int ALARM_EN_BIT = 7;
    // oscillator edges: one rising edge per 1/32768 s
    localparam int OSC_PER_SIXTEENTH = 2048;
    localparam int OSC_PER_TEST_HALF = 32;
    // ticks of 1/16 s per unit code 00..11
    localparam int UNIT_00_TICKS = 1;
    localparam int UNIT_01_TICKS = 4;
    localparam int UNIT_10_TICKS = 16;
    localparam int UNIT_11_TICKS = 64;
    // reset pulse 40..200 ms; two whole 1/16 s ticks from a tick-aligned start give 125 ms
    localparam int RST_PULSE_MS_MIN = 40;
    localparam int RST_PULSE_MS_MAX = 200;
    localparam int RST_PULSE_TICKS = 2;

    typedef struct packed {
        logic steer;
        logic [4:0] mult;
        logic [1:0] unit;
    } wdog_reg_t;

    typedef struct packed {
        logic [18:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic wr;
    } host_req_t;
endpackage
